// ===== hdl/nic_cfg.svh
// constants for the nested interrupt controller
`ifndef NIC_CFG_SVH
`define NIC_CFG_SVH
`define NIC_ADR_ENABLE_MAIN   8'ha8
`define NIC_ADR_LEVEL_MAIN    8'hb8
`define NIC_ADR_PL_FLAGS      8'hc0
`define NIC_ADR_PL_ENABLE     8'he8
`define NIC_ADR_PL_POLARITY   8'he9
`define NIC_ADR_PL_LEVEL      8'hf8
`define NIC_BIT_GATE          7
`define NIC_RESET_BYTE        8'h00
`define NIC_VEC_BASE_PORT     16'h003b
`define NIC_VEC_STEP          16'h0008
`endif

// ===== hdl/nic_pkg.sv
// types for the nested interrupt controller
package nic_pkg;
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } nic_sfr_req_t;
  typedef struct packed {
    logic        valid;
    logic        high;
    logic [3:0]  src;
    logic [15:0] vector;
  } nic_irq_req_t;
endpackage : nic_pkg

// ===== hdl/nic_pick.sv
// fixed-order selection of one source among requests of one level
`timescale 1ns/1ps
module nic_pick
  import nic_pkg::*;
(
  // requests by source index: ext0 timer0 ext1 timer1 serial, then port lines
  input  wire logic [12:0] req_in,
  // result
  output logic             any_out,
  output logic [3:0]       src_out
);
  // polling order, first entry wins: scan from the tail so it is written last
  localparam logic [51:0] ORDER = {4'd0, 4'd4, 4'd8, 4'd1, 4'd9, 4'd2, 4'd5,
                                   4'd10, 4'd3, 4'd6, 4'd11, 4'd7, 4'd12};
  always_comb
  begin
    any_out = 1'b0;
    src_out = 4'd0;
    for (int i = 0; i <= 12; i++)
    begin
      if (req_in[ORDER[i*4 +: 4]])
      begin
        any_out = 1'b1;
        src_out = ORDER[i*4 +: 4];
      end
    end
  end
endmodule : nic_pick

// ===== hdl/nic_top.sv
// two-level nested interrupt controller with port-line request flags
// Overview of operation
// - port-line request flags register at c0h
// - flag bit 7 is irq 9, bit 0 irq 2
// - fixed vector address per accepted source
// - fixed polling order within one level
// - polarity e9h, enable a8h, port enable e8h
// - priority registers at b8h and f8h
// - enabled request sets flag; software clears
// - polarity 1 active high, 0 active low
// - global gate bit blocks all when clear
// - level bit 0 low, 1 high
`include "nic_cfg.svh"
`timescale 1ns/1ps
module nic_top
  import nic_pkg::*;
(
  // clock and reset
  input  wire logic                  clk_in,
  input  wire logic                  reset_in,
  // sfr access from the core
  input  wire nic_pkg::nic_sfr_req_t sfr_in,
  output logic [7:0]                 rdata_out,
  // request sources, same clock
  input  wire logic                  ext0_in,
  input  wire logic                  ext1_in,
  input  wire logic                  timer0_in,
  input  wire logic                  timer1_in,
  input  wire logic                  serial_in,
  // port-line pins, asynchronous
  input  wire logic [7:0]            port_line_in,
  // core handshake
  input  wire logic                  ack_in,
  input  wire logic                  reti_in,
  output nic_pkg::nic_irq_req_t      irq_out
);
  import nic_pkg::*;

  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic [7:0]  source_enable_main_ff;
  logic [7:0]  level_select_main_ff;
  logic [7:0]  portline_request_flags_ff;
  logic [7:0]  portline_source_enable_ff;
  logic [7:0]  portline_polarity_ff;
  logic [7:0]  portline_level_select_ff;
  logic [7:0]  pin_meta_ff;
  logic [7:0]  pin_sync_ff;
  logic        low_active_ff;
  logic        high_active_ff;
  logic [7:0]  rdata_ff;
  nic_irq_req_t irq_ff;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
    hit = a == b;
  endfunction : hit

  wire wr_en_main = sfr_in.wr && hit(sfr_in.addr, `NIC_ADR_ENABLE_MAIN);
  wire wr_lv_main = sfr_in.wr && hit(sfr_in.addr, `NIC_ADR_LEVEL_MAIN);
  wire wr_flags   = sfr_in.wr && hit(sfr_in.addr, `NIC_ADR_PL_FLAGS);
  wire wr_en_pl   = sfr_in.wr && hit(sfr_in.addr, `NIC_ADR_PL_ENABLE);
  wire wr_pol_pl  = sfr_in.wr && hit(sfr_in.addr, `NIC_ADR_PL_POLARITY);
  wire wr_lv_pl   = sfr_in.wr && hit(sfr_in.addr, `NIC_ADR_PL_LEVEL);

  // ----------------------------------------
  // port-line requests
  // ----------------------------------------
  // polarity xnor: 1 selects active high
  wire [7:0] pl_active = ~(pin_sync_ff ^ portline_polarity_ff);
  wire [7:0] pl_set    = pl_active & portline_source_enable_ff;
  // a set in the same cycle as a software clear wins
  wire [7:0] nxt_flags = wr_flags ? (sfr_in.wdata | pl_set)
                                  : (portline_request_flags_ff | pl_set);

  // ----------------------------------------
  // arbitration
  // ----------------------------------------
  wire [12:0] src_pend = {portline_request_flags_ff, serial_in, timer1_in,
                          ext1_in, timer0_in, ext0_in};
  wire [12:0] src_en   = {portline_source_enable_ff, source_enable_main_ff[5],
                          source_enable_main_ff[3:0]};
  wire [12:0] src_lvl  = {portline_level_select_ff, level_select_main_ff[5],
                          level_select_main_ff[3:0]};
  wire        gate     = source_enable_main_ff[`NIC_BIT_GATE];
  wire [12:0] live     = gate ? (src_pend & src_en) : 13'h0000;
  wire [12:0] live_hi  = live & src_lvl;
  wire [12:0] live_lo  = live & ~src_lvl;
  wire        any_hi;
  wire        any_lo;
  wire [3:0]  sel_hi;
  wire [3:0]  sel_lo;

  nic_pick u_pick_hi
  (
    .req_in  (live_hi),
    .any_out (any_hi),
    .src_out (sel_hi)
  );
  nic_pick u_pick_lo
  (
    .req_in  (live_lo),
    .any_out (any_lo),
    .src_out (sel_lo)
  );

  // high needs no high running; low needs nothing running
  wire        take_hi  = any_hi && !high_active_ff;
  wire        take_lo  = any_lo && !high_active_ff && !low_active_ff;
  wire [3:0]  sel      = take_hi ? sel_hi : sel_lo;

  function automatic logic [15:0] vec_of(input logic [3:0] s);
    if (s >= 4'd5)
      vec_of = `NIC_VEC_BASE_PORT + (16'(s - 4'd5) * `NIC_VEC_STEP);
    else if (s == 4'd4)
      vec_of = 16'h002b;
    else
      vec_of = {11'h000, s[1:0], 3'h3}; // 0003 000b 0013 001b
  endfunction : vec_of

  wire [15:0] nxt_vec = vec_of(sel);

  // ----------------------------------------
  // readback
  // ----------------------------------------
  wire [7:0] nxt_rdata =
    hit(sfr_in.addr, `NIC_ADR_ENABLE_MAIN) ? source_enable_main_ff :
    hit(sfr_in.addr, `NIC_ADR_LEVEL_MAIN)  ? level_select_main_ff :
    hit(sfr_in.addr, `NIC_ADR_PL_FLAGS)    ? portline_request_flags_ff :
    hit(sfr_in.addr, `NIC_ADR_PL_ENABLE)   ? portline_source_enable_ff :
    hit(sfr_in.addr, `NIC_ADR_PL_POLARITY) ? portline_polarity_ff :
    hit(sfr_in.addr, `NIC_ADR_PL_LEVEL)    ? portline_level_select_ff : 8'h00;

  // ----------------------------------------
  // flops
  // ----------------------------------------
  always_ff @(posedge clk_in)
  begin
    pin_meta_ff <= port_line_in;
    pin_sync_ff <= pin_meta_ff;
  end

  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      source_enable_main_ff     <= `NIC_RESET_BYTE;
      level_select_main_ff      <= `NIC_RESET_BYTE;
      portline_request_flags_ff <= `NIC_RESET_BYTE;
      portline_source_enable_ff <= `NIC_RESET_BYTE;
      portline_polarity_ff      <= `NIC_RESET_BYTE;
      portline_level_select_ff  <= `NIC_RESET_BYTE;
      rdata_ff                  <= 8'h00;
    end
    else
    begin
      if (wr_en_main) source_enable_main_ff <= sfr_in.wdata;
      if (wr_lv_main) level_select_main_ff <= sfr_in.wdata;
      if (wr_en_pl)   portline_source_enable_ff <= sfr_in.wdata;
      if (wr_pol_pl)  portline_polarity_ff <= sfr_in.wdata;
      if (wr_lv_pl)   portline_level_select_ff <= sfr_in.wdata;
      portline_request_flags_ff <= nxt_flags;
      if (sfr_in.rd) rdata_ff <= nxt_rdata;
    end
  end

  // nesting state: ack marks level running, return pops innermost
  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      low_active_ff  <= 1'b0;
      high_active_ff <= 1'b0;
      irq_ff         <= '0;
    end
    else
    begin
      irq_ff.valid  <= (take_hi || take_lo) && !(ack_in && irq_ff.valid);
      irq_ff.high   <= take_hi;
      irq_ff.src    <= sel;
      irq_ff.vector <= nxt_vec;
      if (ack_in && irq_ff.valid)
      begin
        if (irq_ff.high) high_active_ff <= 1'b1;
        else             low_active_ff  <= 1'b1;
      end
      else if (reti_in)
      begin
        if (high_active_ff) high_active_ff <= 1'b0;
        else                low_active_ff  <= 1'b0;
      end
    end
  end

  assign rdata_out = rdata_ff;
  assign irq_out   = irq_ff;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  property p_gate_blocks;
    @(posedge clk_in) disable iff (reset_in)
      !gate |=> !irq_ff.valid;
  endproperty
  a_gate_blocks: assert property (p_gate_blocks) else $error("request with gate clear");

  property p_flag_sticky;
    @(posedge clk_in) disable iff (reset_in)
      (portline_request_flags_ff[0] && !wr_flags) |=> portline_request_flags_ff[0];
  endproperty
  a_flag_sticky: assert property (p_flag_sticky) else $error("flag cleared by hardware");

  property p_flag_needs_enable;
    @(posedge clk_in) disable iff (reset_in)
      (!portline_request_flags_ff[3] && !portline_source_enable_ff[3] && !wr_flags)
        |=> !portline_request_flags_ff[3];
  endproperty
  a_flag_needs_enable: assert property (p_flag_needs_enable) else $error("disabled flag set");

  property p_no_nest_in_high;
    @(posedge clk_in) disable iff (reset_in)
      high_active_ff |=> !irq_ff.valid;
  endproperty
  a_no_nest_in_high: assert property (p_no_nest_in_high) else $error("preempted high routine");

  property p_low_waits;
    @(posedge clk_in) disable iff (reset_in)
      (low_active_ff && !high_active_ff) |=> !irq_ff.valid || irq_ff.high;
  endproperty
  a_low_waits: assert property (p_low_waits) else $error("low nested in low");

  property p_vec_ext0;
    @(posedge clk_in) disable iff (reset_in)
      (take_hi && sel == 4'd0) |=> irq_ff.vector == 16'h0003;
  endproperty
  a_vec_ext0: assert property (p_vec_ext0) else $error("bad vector external 0");

  property p_vec_ext9;
    @(posedge clk_in) disable iff (reset_in)
      ((take_hi || take_lo) && sel == 4'd12) |=> irq_ff.vector == 16'h0073;
  endproperty
  a_vec_ext9: assert property (p_vec_ext9) else $error("bad vector external 9");

  property p_ext0_first;
    @(posedge clk_in) disable iff (reset_in)
      (take_lo && !take_hi && live_lo[0]) |=> irq_ff.src == 4'd0;
  endproperty
  a_ext0_first: assert property (p_ext0_first) else $error("external 0 not first");

  property p_high_wins;
    @(posedge clk_in) disable iff (reset_in)
      take_hi |=> irq_ff.high && irq_ff.valid == !$past(ack_in && irq_ff.valid);
  endproperty
  a_high_wins: assert property (p_high_wins) else $error("high level lost");
endmodule : nic_top

// ===== testbench/nic_core_model.sv
// core model that takes vectored requests and returns on command
`timescale 1ns/1ps
module nic_core_model
  import nic_pkg::*;
(
  // clock and reset
  input  wire logic                  clk_in,
  input  wire logic                  reset_in,
  // request side
  input  wire nic_pkg::nic_irq_req_t irq_in,
  input  wire logic                  ret_in,
  output logic                       ack_out,
  output logic                       reti_out
);
  // one-cycle ack, not repeated: valid only drops after the ack lands
  always_ff @(posedge clk_in)
  begin
    ack_out  <= !reset_in && irq_in.valid && !ack_out;
    reti_out <= !reset_in && ret_in;
  end
endmodule : nic_core_model

// ===== testbench/tb_top.sv
// self-checking bench for the nested interrupt controller
`timescale 1ns/1ps
module tb_top;
  import nic_pkg::*;
  logic         clk_in;
  logic         reset_in;
  nic_sfr_req_t sfr;
  logic [7:0]   rdata;
  logic [4:0]   msrc;
  logic [7:0]   pins;
  logic         ack;
  logic         reti;
  logic         ret;
  nic_irq_req_t irq;
  int           err_total;
  int           checked;
  int           cyc;
  logic [3:0]   ord [13] = '{4'h0, 4'h4, 4'h8, 4'h1, 4'h9, 4'h2, 4'h5,
                            4'ha, 4'h3, 4'h6, 4'hb, 4'h7, 4'hc};
  // flags written last so the pins seen through the new enables do not add bits
  logic [7:0]   adr [6] = '{8'ha8, 8'hb8, 8'he8, 8'he9, 8'hf8, 8'hc0};

  nic_top dut (.clk_in(clk_in), .reset_in(reset_in), .sfr_in(sfr), .rdata_out(rdata),
    .ext0_in(msrc[0]), .timer0_in(msrc[1]), .ext1_in(msrc[2]), .timer1_in(msrc[3]),
    .serial_in(msrc[4]), .port_line_in(pins), .ack_in(ack), .reti_in(reti), .irq_out(irq));
  nic_core_model core (.clk_in(clk_in), .reset_in(reset_in), .irq_in(irq), .ret_in(ret),
    .ack_out(ack), .reti_out(reti));

  function automatic logic [15:0] vec(input logic [3:0] s);
    vec = (s < 4'h4) ? 16'h0003 + 16'h0008 * s :
          (s == 4'h4) ? 16'h002b : 16'h003b + 16'h0008 * (s - 4'h5);
  endfunction : vec

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
  begin
    checked++;
    if (got !== exp)
    begin
      $display("unexpected %0t got %h want %h", $time, got, exp);
      err_total++;
    end
  end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
  begin
    @(posedge clk_in) sfr <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk_in) sfr <= '0;
  end
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
  begin
    @(posedge clk_in) sfr <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk_in) sfr <= '0;
    #1 chk(rdata, exp);
  end
  endtask : rd

  task automatic wait_irq(input logic [3:0] s, input logic h);
    int i;
  begin
    i = 0;
    do
    begin
      @(posedge clk_in);
      #1 i++;
    end while (irq.valid !== 1'b1 && i < 30);
    chk(irq.valid, 1'b1);
    chk(irq.src, s);
    chk(irq.high, h);
    chk(irq.vector, vec(s));
  end
  endtask : wait_irq

  task automatic ret_pulse();
  begin
    @(posedge clk_in) ret <= 1'b1;
    @(posedge clk_in) ret <= 1'b0;
  end
  endtask : ret_pulse

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_regs();
  begin
    foreach (adr[i]) rd(adr[i], 8'h00);
    rd(8'h10, 8'h00);
    // pattern keeps the gate bit clear, so nothing is vectored here
    foreach (adr[i]) wr(adr[i], 8'ha5 ^ adr[i]);
    foreach (adr[i]) rd(adr[i], 8'ha5 ^ adr[i]);
    foreach (adr[i]) wr(adr[i], 8'h00);
  end
  endtask : t_regs

  task automatic t_flags();
  begin
    // pins settle inactive before the enable, or a low pin sets the flag
    @(posedge clk_in) pins <= 8'h7f;
    repeat (3) @(posedge clk_in);
    wr(8'he8, 8'h01);
    repeat (6) @(posedge clk_in);
    rd(8'hc0, 8'h00);
    @(posedge clk_in) pins <= 8'hfe;
    repeat (6) @(posedge clk_in) pins <= 8'hff;
    rd(8'hc0, 8'h01);
    wr(8'he8, 8'h80);
    @(posedge clk_in) pins <= 8'h7f;
    repeat (6) @(posedge clk_in);
    rd(8'hc0, 8'h81);
    wr(8'he8, 8'h00);
    wr(8'hc0, 8'h00);
    rd(8'hc0, 8'h00);
  end
  endtask : t_flags

  task automatic t_gate();
  begin
    wr(8'ha8, 8'h2f);
    @(posedge clk_in) msrc <= 5'h1f;
    repeat (6) @(posedge clk_in);
    #1 chk(irq.valid, 1'b0);
    wr(8'ha8, 8'haf);
    wait_irq(4'h0, 1'b0);
    @(posedge clk_in) msrc <= 5'h00;
    ret_pulse();
  end
  endtask : t_gate

  task automatic t_order();
    logic [7:0] f;
  begin
    f = 8'hff;
    wr(8'he9, 8'hff);
    wr(8'he8, 8'hff);
    @(posedge clk_in) pins <= 8'hff;
    msrc <= 5'h1f;
    foreach (ord[i])
    begin
      wait_irq(ord[i], 1'b0);
      repeat (3) @(posedge clk_in);
      #1 chk(irq.valid, 1'b0);
      @(posedge clk_in);
      if (ord[i] < 4'h5) msrc[ord[i]] <= 1'b0;
      else pins[ord[i] - 4'h5] <= 1'b0;
      if (ord[i] >= 4'h5) f[ord[i] - 4'h5] = 1'b0;
      repeat (5) @(posedge clk_in);
      wr(8'hc0, f);
      ret_pulse();
    end
  end
  endtask : t_order

  task automatic t_preempt();
  begin
    wr(8'hf8, 8'h80);
    @(posedge clk_in) msrc <= 5'h01;
    wait_irq(4'h0, 1'b0);
    @(posedge clk_in) pins <= 8'h80;
    wait_irq(4'hc, 1'b1);
  end
  endtask : t_preempt

  task automatic report_and_stop();
  begin
    if (err_total == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  end
  endtask : report_and_stop

  initial
  begin
    clk_in = 1'b0;
    forever #2.5 clk_in = ~clk_in;
  end

  // the ceiling sits far above the few hundred cycles the scenarios take
  always @(posedge clk_in)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_total++;
      report_and_stop();
    end
  end

  initial
  begin
    reset_in = 1'b1;
    sfr = '0;
    msrc = 5'h00;
    pins = 8'h00;
    ret = 1'b0;
    err_total = 0;
    checked = 0;
    cyc = 0;
    repeat (2) @(posedge clk_in);
    reset_in <= 1'b0;
    t_regs();
    t_flags();
    t_gate();
    t_order();
    t_preempt();
    report_and_stop();
  end
endmodule : tb_top
